/* File: rsp_pkg.sv */
// Shared constants, types and register map of the radio serial port block.
package rsp_pkg;
    // ==========================================================
    // Register map (byte offsets) and status bit positions
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_STAT = 5'h04;
    localparam logic [4:0] A_MASK = 5'h08;
    localparam logic [4:0] A_TXD  = 5'h0C;
    localparam logic [4:0] A_RXD  = 5'h10;
    localparam logic [4:0] A_INFO = 5'h14;
    localparam logic [4:0] A_VOL  = 5'h18;
    localparam int ST_RXV  = 0;
    localparam int ST_FERR = 1;
    localparam int ST_TXE  = 2;
    localparam int ST_TALK = 3;
    localparam int ST_HOOK = 4;
    localparam int ST_PWRQ = 5;
    localparam int ST_W    = 6;
    // ==========================================================
    // Frame, flow control and timing constants
    localparam int DATA_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] XON_CHAR  = 8'h11;
    localparam logic [7:0] XOFF_CHAR = 8'h13;
    localparam int CLK_HZ_DEF  = 40_000_000;
    localparam int MIRROR_US   = 500;
    localparam int KEY_MS      = 50;
    localparam int MIN_RATE    = 1200;
    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        F_IDLE  = 4'h1,
        F_START = 4'h2,
        F_DATA  = 4'h4,
        F_STOP  = 4'h8
    } rsp_frame_e;
    typedef struct packed {
        logic [7:0] min_vol;
        logic [2:0] baud_sel;
        logic       port_aux;
        logic       hs_en;
        logic       mirror_en;
        logic       auto_pwr;
        logic       pwr_off;
    } rsp_ctrl_s;
    localparam rsp_ctrl_s CTRL_RST = '{min_vol: 8'h10, baud_sel: 3'h3, port_aux: 1'b0,
        hs_en: 1'b0, mirror_en: 1'b0, auto_pwr: 1'b1, pwr_off: 1'b0};
    localparam logic [ST_W-1:0] MASK_RST = 6'h00;
    // Clock cycles per bit for each selectable rate.
    function automatic int baud_div(input int clk_hz, input logic [2:0] sel);
        int rate;
        rate = 9600;
        unique case (sel)
            3'h0: rate = 1200;
            3'h1: rate = 2400;
            3'h2: rate = 4800;
            3'h3: rate = 9600;
            3'h4: rate = 14400;
            3'h5: rate = 19200;
            default: rate = 28800;
        endcase
        return clk_hz / rate;
    endfunction
endpackage

/* File: rsp_serial_port.sv */
// Radio body serial port with flow control, head detection and control lines.
`timescale 1ns/1ps
`default_nettype none
module rsp_serial_port import rsp_pkg::*; #(
    parameter int CLK_HZ = CLK_HZ_DEF,
    parameter int MIRROR_CYC = (CLK_HZ / 1_000_000) * MIRROR_US,
    parameter int KEY_CYC = (CLK_HZ / 1000) * KEY_MS
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    input  wire logic        mic_rxd,
    output logic             mic_txd,
    input  wire logic        aux_rxd,
    output logic             aux_txd,
    input  wire logic        high_speed_data_mode,
    input  wire logic        talk_request_hook_in,
    output logic             talk_active,
    output logic             off_hook,
    input  wire logic        mirror_src_in,
    output logic             mic_port_general_io_o,
    output logic             mic_port_general_io_oe,
    input  wire logic        head_ui_present,
    input  wire logic        head_blank,
    input  wire logic [7:0]  vol_pot_level,
    output logic      [7:0]  rx_volume,
    input  wire logic        pwr_on_off_b_i,
    output logic             pwr_on_off_b_o,
    output logic             pwr_on_off_b_oe,
    output logic             radio_power_on
);
    localparam int DIVW   = $clog2(CLK_HZ / MIN_RATE + 1);
    localparam int MIR_DB = MIRROR_CYC / 2;
    localparam int TALK_CYC = KEY_CYC / 2;
    localparam int MW = $clog2(MIRROR_CYC + 2);
    localparam int KW = $clog2(KEY_CYC + 1);

    // ==========================================================
    // Bus slave and registers
    rsp_ctrl_s ctrl_q, ctrl_d;
    logic [ST_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
    logic [31:0] rdata_q, rdata_d;
    logic rd_ack_q, rd_ack_d, irq_q, irq_d, wr_ok, rd_ok, use_aux, mic_blk;
    logic [DIVW-1:0] div;
    logic tx_full_q, rx_full_q, paused_q, talk_q, hook_q, radio_on_q;
    logic [7:0] tx_hold_q, rx_data_q, vol_q;
    rsp_frame_e tx_st_q, rx_st_q;

    assign use_aux = ctrl_q.port_aux | ctrl_q.hs_en;
    assign mic_blk = high_speed_data_mode & ~use_aux;
    assign div = DIVW'(baud_div(CLK_HZ, ctrl_q.baud_sel));
    // A write to a full transmit holding register stalls the master.
    assign avs_waitrequest = (avs_read & ~rd_ack_q)
        | (avs_write & (avs_address == A_TXD) & tx_full_q);
    assign wr_ok = avs_write & ~avs_waitrequest;
    assign rd_ok = avs_read & rd_ack_q;
    assign avs_readdata = rdata_q;
    assign irq = irq_q;

    always_comb begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        stat_d = stat_q | ev;
        rd_ack_d = avs_read & ~rd_ack_q;
        rdata_d = rdata_q;
        if (wr_ok) begin
            unique case (avs_address)
                A_CTRL: ctrl_d = avs_writedata[15:0];
                A_MASK: mask_d = avs_writedata[ST_W-1:0];
                // Clearing loses no event: a new one is ORed in afterwards.
                A_STAT: stat_d = (stat_q & ~avs_writedata[ST_W-1:0]) | ev;
                default: ;
            endcase
        end
        if (avs_read & ~rd_ack_q) begin
            unique case (avs_address)
                A_CTRL: rdata_d = {16'h0000, ctrl_q};
                A_STAT: rdata_d = {26'h0000000, stat_q};
                A_MASK: rdata_d = {26'h0000000, mask_q};
                A_TXD:  rdata_d = {23'h000000, tx_full_q, tx_hold_q};
                A_RXD:  rdata_d = {23'h000000, rx_full_q, rx_data_q};
                A_INFO: rdata_d = {24'h000000, talk_q, hook_q, paused_q, tx_st_q != F_IDLE,
                                   radio_on_q, head_ui_present, head_blank, use_aux};
                A_VOL:  rdata_d = {24'h000000, vol_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= CTRL_RST;
            mask_q <= MASK_RST;
            stat_q <= '0;
            rd_ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            rd_ack_q <= rd_ack_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    // ==========================================================
    // Transmitter
    rsp_frame_e tx_st_d;
    logic [DIVW-1:0] tx_cnt_q, tx_cnt_d;
    logic [2:0] tx_bit_q, tx_bit_d;
    logic [7:0] tx_sh_q, tx_sh_d, tx_hold_d;
    logic tx_full_d, tx_line_q, tx_line_d, tx_tick, mic_txd_q, mic_txd_d, aux_txd_q, aux_txd_d;

    assign tx_tick = tx_cnt_q == div - 1'b1;

    always_comb begin
        tx_st_d = tx_st_q;
        tx_cnt_d = tx_tick ? '0 : tx_cnt_q + 1'b1;
        tx_bit_d = tx_bit_q;
        tx_sh_d = tx_sh_q;
        tx_hold_d = tx_hold_q;
        tx_full_d = tx_full_q;
        tx_line_d = tx_line_q;
        ev[ST_TXE] = 1'b0;
        if (wr_ok && avs_address == A_TXD) begin
            tx_hold_d = avs_writedata[7:0];
            tx_full_d = 1'b1;
        end
        unique case (tx_st_q)
            F_IDLE: begin
                tx_cnt_d = '0;
                tx_line_d = 1'b1;
                if (tx_full_q && !paused_q && !mic_blk) begin
                    tx_sh_d = tx_hold_q;
                    tx_full_d = 1'b0;
                    ev[ST_TXE] = 1'b1;
                    tx_line_d = 1'b0;
                    tx_st_d = F_START;
                end
            end
            F_START: if (tx_tick) begin
                tx_line_d = tx_sh_q[0];
                tx_bit_d = 3'h0;
                tx_st_d = F_DATA;
            end
            F_DATA: if (tx_tick) begin
                tx_sh_d = {1'b0, tx_sh_q[7:1]};
                tx_bit_d = tx_bit_q + 1'b1;
                tx_line_d = tx_sh_q[1];
                if (tx_bit_q == LAST_BIT) begin
                    tx_line_d = 1'b1;
                    tx_st_d = F_STOP;
                end
            end
            F_STOP: if (tx_tick) tx_st_d = F_IDLE;
            default: tx_st_d = F_IDLE;
        endcase
        // The port not in use, or the blocked mic port, idles high.
        mic_txd_d = (use_aux || mic_blk) ? 1'b1 : tx_line_d;
        aux_txd_d = use_aux ? tx_line_d : 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_q <= F_IDLE;
            tx_cnt_q <= '0;
            tx_bit_q <= 3'h0;
            tx_sh_q <= 8'h00;
            tx_hold_q <= 8'h00;
            tx_full_q <= 1'b0;
            tx_line_q <= 1'b1;
            mic_txd_q <= 1'b1;
            aux_txd_q <= 1'b1;
        end else begin
            tx_st_q <= tx_st_d;
            tx_cnt_q <= tx_cnt_d;
            tx_bit_q <= tx_bit_d;
            tx_sh_q <= tx_sh_d;
            tx_hold_q <= tx_hold_d;
            tx_full_q <= tx_full_d;
            tx_line_q <= tx_line_d;
            mic_txd_q <= mic_txd_d;
            aux_txd_q <= aux_txd_d;
        end
    end
    assign mic_txd = mic_txd_q;
    assign aux_txd = aux_txd_q;

    // ==========================================================
    // Receiver with XON/XOFF detection
    rsp_frame_e rx_st_d;
    logic [DIVW-1:0] rx_cnt_q, rx_cnt_d;
    logic [2:0] rx_bit_q, rx_bit_d;
    logic [7:0] rx_sh_q, rx_sh_d, rx_data_d;
    logic rx_full_d, paused_d, rxd, rx_tick;

    // A blocked mic port reads as an idle line.
    assign rxd = use_aux ? aux_rxd : (mic_blk | mic_rxd);
    // The start state waits half a bit so later samples fall at bit centres.
    assign rx_tick = (rx_st_q == F_START) ? (rx_cnt_q == (div >> 1)) : (rx_cnt_q == div - 1'b1);

    always_comb begin
        rx_st_d = rx_st_q;
        rx_cnt_d = rx_tick ? '0 : rx_cnt_q + 1'b1;
        rx_bit_d = rx_bit_q;
        rx_sh_d = rx_sh_q;
        rx_data_d = rx_data_q;
        rx_full_d = rx_full_q & ~(rd_ok && avs_address == A_RXD);
        paused_d = paused_q;
        ev[ST_RXV] = 1'b0;
        ev[ST_FERR] = 1'b0;
        unique case (rx_st_q)
            F_IDLE: begin
                rx_cnt_d = '0;
                if (!rxd) rx_st_d = F_START;
            end
            F_START: if (rx_tick) begin
                rx_bit_d = 3'h0;
                rx_st_d = rxd ? F_IDLE : F_DATA;
            end
            F_DATA: if (rx_tick) begin
                rx_sh_d = {rxd, rx_sh_q[7:1]};
                rx_bit_d = rx_bit_q + 1'b1;
                if (rx_bit_q == LAST_BIT) rx_st_d = F_STOP;
            end
            F_STOP: if (rx_tick) begin
                rx_st_d = F_IDLE;
                if (!rxd) ev[ST_FERR] = 1'b1;
                else if (rx_sh_q == XOFF_CHAR) paused_d = 1'b1;
                else if (rx_sh_q == XON_CHAR) paused_d = 1'b0;
                else begin
                    rx_data_d = rx_sh_q;
                    rx_full_d = 1'b1;
                    ev[ST_RXV] = 1'b1;
                end
            end
            default: rx_st_d = F_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_st_q <= F_IDLE;
            rx_cnt_q <= '0;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_data_q <= 8'h00;
            rx_full_q <= 1'b0;
            paused_q <= 1'b0;
        end else begin
            rx_st_q <= rx_st_d;
            rx_cnt_q <= rx_cnt_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q <= rx_sh_d;
            rx_data_q <= rx_data_d;
            rx_full_q <= rx_full_d;
            paused_q <= paused_d;
        end
    end

    // ==========================================================
    // Mirror, talk/hook, volume and power control
    logic [MW-1:0] mir_cnt_q, mir_cnt_d;
    logic [KW-1:0] tk_cnt_q, tk_cnt_d;
    logic mir_q, mir_d, oe_q, oe_d, talk_d, hook_d, radio_on_d, pwr_req, preq_q, pwr_oe_q;
    logic [7:0] vol_d;

    // Our own power-off drive must not read back as a power-on request.
    assign pwr_req = ~pwr_on_off_b_i & ~pwr_oe_q;

    always_comb begin
        mir_d = mir_q;
        mir_cnt_d = '0;
        if (mirror_src_in != mir_q) begin
            mir_cnt_d = mir_cnt_q + 1'b1;
            if (mir_cnt_q == MW'(MIR_DB - 1)) begin
                mir_d = mirror_src_in;
                mir_cnt_d = '0;
            end
        end
        oe_d = ctrl_q.mirror_en & ~mir_d;
        talk_d = talk_q;
        hook_d = hook_q;
        tk_cnt_d = '0;
        ev[ST_TALK] = 1'b0;
        ev[ST_HOOK] = 1'b0;
        if (!talk_request_hook_in) begin
            tk_cnt_d = (tk_cnt_q == KW'(TALK_CYC - 1)) ? tk_cnt_q : tk_cnt_q + 1'b1;
            if (tk_cnt_q == KW'(TALK_CYC - 1) && !talk_q) begin
                talk_d = 1'b1;
                ev[ST_TALK] = 1'b1;
            end
        end else begin
            talk_d = 1'b0;
            // A released low of at least MIR_DB cycles but shorter than the talk time is a hookswitch change.
            if (!talk_q && tk_cnt_q >= KW'(MIR_DB)) begin
                hook_d = ~hook_q;
                ev[ST_HOOK] = 1'b1;
            end
        end
        vol_d = head_ui_present ? vol_pot_level : ctrl_q.min_vol;
        radio_on_d = ~ctrl_q.pwr_off
            & (radio_on_q | pwr_req | (ctrl_q.auto_pwr & ~head_ui_present));
        ev[ST_PWRQ] = pwr_req & ~preq_q;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mir_q <= 1'b1;
            mir_cnt_q <= '0;
            oe_q <= 1'b0;
            talk_q <= 1'b0;
            hook_q <= 1'b0;
            tk_cnt_q <= '0;
            vol_q <= 8'h00;
            radio_on_q <= 1'b0;
            preq_q <= 1'b0;
            pwr_oe_q <= 1'b0;
        end else begin
            mir_q <= mir_d;
            mir_cnt_q <= mir_cnt_d;
            oe_q <= oe_d;
            talk_q <= talk_d;
            hook_q <= hook_d;
            tk_cnt_q <= tk_cnt_d;
            vol_q <= vol_d;
            radio_on_q <= radio_on_d;
            preq_q <= pwr_req;
            pwr_oe_q <= ctrl_q.pwr_off;
        end
    end
    assign mic_port_general_io_o = 1'b0;
    assign mic_port_general_io_oe = oe_q;
    assign talk_active = talk_q;
    assign off_hook = hook_q;
    assign rx_volume = vol_q;
    assign pwr_on_off_b_o = 1'b0;
    assign pwr_on_off_b_oe = pwr_oe_q;
    assign radio_power_on = radio_on_q;

    // ==========================================================
    // Assertions
    logic [MW-1:0] lag_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) lag_q <= '0;
        else lag_q <= (ctrl_q.mirror_en && oe_q == mirror_src_in) ? lag_q + 1'b1 : '0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_tx_idle_high: assert property (tx_st_q == F_IDLE |-> tx_line_q)
        else $error("line not high while idle");
    a_tx_frame_bits: assert property ((tx_st_q == F_START |-> !tx_line_q)
        and (tx_st_q == F_STOP |-> tx_line_q))
        else $error("start or stop bit level wrong");
    a_bit_time_hold: assert property (tx_st_q == F_START && !tx_tick |=> tx_st_q == F_START)
        else $error("start bit shorter than one bit time");
    a_xoff_holds_tx: assert property (paused_q && tx_st_q == F_IDLE |=> tx_st_q == F_IDLE)
        else $error("transmit started while paused");
    a_mic_blocked: assert property (mic_blk |=> mic_txd_q)
        else $error("mic port driven during high-speed data");
    a_stop_low_err: assert property (rx_st_q == F_STOP && rx_tick && !rxd |=> stat_q[ST_FERR])
        else $error("framing error not flagged");
    a_mirror_delay: assert property (lag_q <= MW'(MIRROR_CYC))
        else $error("mirrored output late");
    a_talk_in_time: assert property (!talk_request_hook_in && tk_cnt_q == KW'(TALK_CYC - 1)
        |=> talk_q)
        else $error("talk request not reported in time");
    a_volume_select: assert property (!head_ui_present |=> vol_q == $past(ctrl_q.min_vol))
        else $error("minimum volume not applied");
    a_power_off_drv: assert property (ctrl_q.pwr_off |=> !radio_on_q && pwr_oe_q)
        else $error("software power-off not applied");
    a_auto_power_up: assert property (ctrl_q.auto_pwr && !head_ui_present && !ctrl_q.pwr_off
        |=> radio_on_q)
        else $error("automatic power-up missing");
endmodule
`default_nettype wire

/* File: rsp_far_end.sv */
// Behavioural far end of the serial link: a control head or programming computer.
`timescale 1ns/1ps
`default_nettype none
module rsp_far_end import rsp_pkg::*; (
    input  wire logic        clk,
    input  wire logic [31:0] bit_cyc,
    input  wire logic        line_in,
    output logic             line_out
);
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    initial line_out = 1'b1;
    // ==========================================================
    // Receiver: bit timing follows the rate the bench selected
    always begin
        @(negedge line_in);
        repeat (bit_cyc / 2) @(posedge clk);
        if (line_in === 1'b0) begin
            for (int i = 0; i < DATA_BITS; i++) begin
                repeat (bit_cyc) @(posedge clk);
                sh[i] = line_in;
            end
            repeat (bit_cyc) @(posedge clk);
            if (line_in === 1'b1) rx_q.push_back(sh);
        end
    end
    // ==========================================================
    // Transmitter; a low stop level lets the bench force a framing fault
    task automatic send(input logic [7:0] data, input logic stop);
        @(posedge clk);
        line_out <= 1'b0;
        repeat (bit_cyc) @(posedge clk);
        for (int i = 0; i < DATA_BITS; i++) begin
            line_out <= data[i];
            repeat (bit_cyc) @(posedge clk);
        end
        line_out <= stop;
        repeat (bit_cyc) @(posedge clk);
        line_out <= 1'b1;
        repeat (bit_cyc) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: rsp_serial_port_tb.sv */
// Self-checking testbench of the radio serial port with a far-end model.
`timescale 1ns/1ps
`default_nettype none
module rsp_serial_port_tb import rsp_pkg::*; ;
    // ==========================================================
    // Setup: shortened counts keep the run brief
    localparam int CLK = 1_200_000;
    localparam int MIR = 40;
    localparam int KEY = 200;
    int          rates[7] = '{1200, 2400, 4800, 9600, 14400, 19200, 28800};
    int          n_fail = 0, num_checks = 0, cyc = 0, mic_low = 0;
    logic        sys_clk, rst_b, avs_read, avs_write, avs_waitrequest, irq, mic_rxd, mic_txd;
    logic        aux_rxd, aux_txd, high_speed_data_mode, talk_request_hook_in, talk_active;
    logic        off_hook, mirror_src_in, gpio_o, gpio_oe, head_ui_present, head_blank;
    logic        pwr_o, pwr_oe, pwr_line, radio_power_on, pwr_req_b, aux_sel, watch;
    logic        far_in, far_out;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q, bitc;
    logic [7:0]  vol_pot_level, rx_volume, b, min_v;
    assign far_in   = aux_sel ? aux_txd : mic_txd;
    assign mic_rxd  = aux_sel ? 1'b1 : far_out;
    assign aux_rxd  = aux_sel ? far_out : 1'b1;
    assign pwr_line = pwr_oe ? 1'b0 : pwr_req_b;
    rsp_serial_port #(.CLK_HZ(CLK), .MIRROR_CYC(MIR), .KEY_CYC(KEY)) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .mic_rxd(mic_rxd), .mic_txd(mic_txd),
        .aux_rxd(aux_rxd), .aux_txd(aux_txd), .high_speed_data_mode(high_speed_data_mode),
        .talk_request_hook_in(talk_request_hook_in), .talk_active(talk_active),
        .off_hook(off_hook), .mirror_src_in(mirror_src_in), .mic_port_general_io_o(gpio_o),
        .mic_port_general_io_oe(gpio_oe), .head_ui_present(head_ui_present),
        .head_blank(head_blank), .vol_pot_level(vol_pot_level), .rx_volume(rx_volume),
        .pwr_on_off_b_i(pwr_line), .pwr_on_off_b_o(pwr_o), .pwr_on_off_b_oe(pwr_oe),
        .radio_power_on(radio_power_on));
    rsp_far_end far (.clk(sys_clk), .bit_cyc(bitc), .line_in(far_in), .line_out(far_out));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (watch && mic_txd !== 1'b1) mic_low <= mic_low + 1;
        if (cyc == 100000) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end
    // ==========================================================
    // Tasks
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    // Each request is launched just after a rising edge and held until waitrequest is
    // sampled low at a rising edge; that edge alone takes the write or the read data.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic setc(input logic [2:0] s, input logic [4:0] f);
        bitc = CLK / rates[s];
        bus(1'b1, A_CTRL, {16'h0, min_v, s, f});
    endtask
    task automatic far_rx(input logic [7:0] exp);
        for (int k = 0; k < 20 * bitc && far.rx_q.size() == 0; k++) @(posedge sys_clk);
        if (far.rx_q.size() == 0) chk("far end frame count", 0, 1);
        else chk("far end byte", far.rx_q.pop_front(), exp);
    endtask
    task automatic dev_rx(input logic [7:0] d);
        far.send(d, 1'b1);
        bus(1'b0, A_RXD, 32'h0);
        chk("rx register", q[8:0], {1'b1, d});
    endtask
    // Flow-control codes are avoided here because the receiver swallows them.
    function automatic logic [7:0] rb();
        return 8'($urandom_range(255, 20));
    endfunction
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'hE531));
        {rst_b, avs_read, avs_write, high_speed_data_mode, aux_sel, watch} = 6'h00;
        {head_ui_present, head_blank} = 2'h0;
        {talk_request_hook_in, mirror_src_in, pwr_req_b} = 3'h7;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        vol_pot_level = 8'h00;
        min_v = 8'h10;
        bitc = CLK / 9600;
        repeat (10) @(negedge sys_clk);
        chk("txd in reset", {mic_txd, aux_txd, irq}, 3'h6);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("auto power up", radio_power_on, 1);
        bus(1'b0, A_CTRL, 32'h0);
        chk("ctrl reset", q, 32'h1062);
        bus(1'b0, 5'h1C, 32'h0);
        chk("unmapped read", q, 32'h0);
        for (int s = 0; s < 7; s++) begin
            setc(s[2:0], 5'h02);
            b = (s == 0) ? 8'h00 : (s == 6) ? 8'hFF : rb();
            bus(1'b1, A_TXD, {24'h0, b});
            far_rx(b);
            dev_rx(s == 3 ? 8'hFF : rb());
        end
        bus(1'b1, A_STAT, 32'h3F);
        bus(1'b1, A_MASK, 32'h00);
        far.send(8'hA5, 1'b0);
        repeat (2) @(negedge sys_clk);
        chk("masked irq", irq, 0);
        bus(1'b1, A_MASK, 32'h02);
        repeat (2) @(negedge sys_clk);
        chk("irq on framing error", irq, 1);
        bus(1'b0, A_STAT, 32'h0);
        chk("framing status", q[5:0], 6'h02);
        bus(1'b1, A_STAT, 32'h02);
        repeat (2) @(negedge sys_clk);
        chk("irq cleared", irq, 0);
        far.send(XOFF_CHAR, 1'b1);
        mic_low = 0;
        watch = 1'b1;
        b = rb();
        bus(1'b1, A_TXD, {24'h0, b});
        bus(1'b0, A_TXD, 32'h0);
        chk("tx holding", q[8:0], {1'b1, b});
        bus(1'b0, A_INFO, 32'h0);
        chk("info flags", q[7:0], 8'h28);
        repeat (30 * bitc) @(negedge sys_clk);
        chk("tx while paused", mic_low, 0);
        watch = 1'b0;
        far.send(XON_CHAR, 1'b1);
        far_rx(b);
        bus(1'b0, A_STAT, 32'h0);
        chk("flow codes kept out of rx", q[0], 0);
        chk("tx emptied event", q[2], 1);
        @(posedge sys_clk);
        high_speed_data_mode <= 1'b1;
        far.send(rb(), 1'b1);
        bus(1'b0, A_STAT, 32'h0);
        chk("mic rx during fast data", q[0], 0);
        setc(3'h6, 5'h0A);
        aux_sel <= 1'b1;
        mic_low = 0;
        watch = 1'b1;
        b = rb();
        bus(1'b1, A_TXD, {24'h0, b});
        far_rx(b);
        dev_rx(rb());
        chk("mic idle during fast data", mic_low, 0);
        watch = 1'b0;
        aux_sel <= 1'b0;
        high_speed_data_mode <= 1'b0;
        @(posedge sys_clk);
        talk_request_hook_in <= 1'b0;
        repeat (KEY / 2 + 8) @(negedge sys_clk);
        chk("talk held", talk_active, 1);
        @(posedge sys_clk);
        talk_request_hook_in <= 1'b1;
        repeat (MIR) @(negedge sys_clk);
        chk("talk released", {talk_active, off_hook}, 2'b00);
        for (int p = 0; p < 3; p++) begin
            @(posedge sys_clk);
            talk_request_hook_in <= 1'b0;
            repeat (p == 0 ? MIR / 4 : MIR) @(posedge sys_clk);
            talk_request_hook_in <= 1'b1;
            repeat (MIR) @(negedge sys_clk);
            chk("hook state", off_hook, p == 1);
        end
        bus(1'b0, A_STAT, 32'h0);
        chk("talk and hook events", q[4:3], 2'b11);
        setc(3'h6, 5'h06);
        for (int m = 0; m < 2; m++) begin
            @(posedge sys_clk);
            mirror_src_in <= m[0];
            repeat (MIR + 3) @(negedge sys_clk);
            chk("mirror drive", {gpio_o, gpio_oe}, {1'b0, !m[0]});
        end
        @(posedge sys_clk);
        head_ui_present <= 1'b1;
        vol_pot_level <= 8'($urandom);
        repeat (3) @(negedge sys_clk);
        chk("pot volume", rx_volume, vol_pot_level);
        min_v = 8'h5A;
        @(posedge sys_clk);
        head_ui_present <= 1'b0;
        head_blank <= 1'b1;
        setc(3'h6, 5'h02);
        repeat (3) @(negedge sys_clk);
        chk("blank head volume", rx_volume, min_v);
        bus(1'b0, A_VOL, 32'h0);
        chk("volume register", q[7:0], min_v);
        @(posedge sys_clk);
        head_ui_present <= 1'b1;
        head_blank <= 1'b0;
        setc(3'h6, 5'h03);
        repeat (2) @(negedge sys_clk);
        chk("power off drive", {pwr_o, pwr_oe, radio_power_on}, 3'b010);
        setc(3'h6, 5'h00);
        bus(1'b1, A_STAT, 32'h3F);
        @(posedge sys_clk);
        pwr_req_b <= 1'b0;
        repeat (MIR) @(negedge sys_clk);
        chk("power on request", radio_power_on, 1);
        bus(1'b0, A_STAT, 32'h0);
        chk("power request event", q[5], 1);
        pwr_req_b <= 1'b1;
        print_verdict();
    end
endmodule
`default_nettype wire
